// ---- tape_rewind_and_diagnostic_cmds_test.sv ----
// Self-checking bench of the rewind and diagnostic command block.
// Assumes the mechanics model trdc_mech beside the design.
module tape_rewind_and_diagnostic_cmds_test;
  import trdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, rst_b_i, s_awvalid_i, s_wvalid_i, s_bready_i;
  logic s_arvalid_i, s_rready_i, s_awready_o, s_wready_o, s_bvalid_o;
  logic s_arready_o, s_rvalid_o, buf_pending_i, stale_buf_i;
  logic flush_done_i, flush_err_i, test_done_i, at_start_i;
  logic flush_req_o, test_req_o, rewind_req_o;
  logic [7:0]  s_awaddr_i, s_araddr_i, dump_data_i;
  logic [31:0] s_wdata_i, s_rdata_o, d;
  logic [1:0]  s_bresp_o, s_rresp_o, r;
  logic [3:0]  s_wstrb_i, cfg;
  logic [15:0] dump_addr_o;
  logic [31:0] x = 32'd10016; // Random state, fixed seed.
  int err_count, checks_done;
  localparam logic [27:0] GD = 28'h0; // Good, no sense.
  localparam logic [27:0] ILL = {ASCQ_FIELD, ASC_FIELD, SK_ILLEGAL, ST_CHECK};
  trdc_cmd uut (.core_clk_i, .rst_b_i, .s_awaddr_i, .s_awvalid_i,
    .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o,
    .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i,
    .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i,
    .at_start_i, .buf_pending_i, .stale_buf_i, .flush_done_i,
    .flush_err_i, .cart_present_i(cfg[2]), .test_done_i,
    .test_pass_i(cfg[0]), .dump_data_i, .rewind_req_o, .flush_req_o,
    .discard_o(), .test_req_o, .test_sel_o(), .sync_cancel_o(),
    .trace_clear_o(), .unload_dis_o(), .bus_release_o(),
    .status_valid_o(), .status_byte_o(), .dump_addr_o, .dump_region_o());
  trdc_mech mech (.core_clk_i, .rst_b_i, .cfg_i(cfg),
    .flush_req_i(flush_req_o), .test_req_i(test_req_o),
    .rewind_req_i(rewind_req_o), .dump_addr_i(dump_addr_o),
    .at_start_o(at_start_i), .flush_done_o(flush_done_i),
    .flush_err_o(flush_err_i), .test_done_o(test_done_i),
    .dump_data_o(dump_data_i));
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  // Test codes 100/101 want no cartridge, 110/111 want one.
  function automatic logic [27:0] dexp(logic [2:0] s, logic c, logic p);
    if (!s[2] || s[1] != c) return ILL;
    return p ? GD : {16'h0, SK_HW, ST_CHECK};
  endfunction : dexp
  function automatic logic [47:0] dg(logic [2:0] s, logic pf, md,
                                     logic [15:0] pl);
    return {md, 7'h0, pl[7:0], pl[15:8], 11'h0, pf, 1'b0, s, OP_DIAG};
  endfunction : dg
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One AXI4-Lite write (w=1) or read (w=0); waits for the answer.
  task automatic bus(input bit w, input logic [7:0] a,
                     input logic [31:0] wd);
    bit pa, pw, ta, tw, tb;
    @(posedge core_clk_i);
    pa = 1;
    pw = w;
    s_awaddr_i <= a;
    s_araddr_i <= a;
    s_wdata_i <= wd;
    s_awvalid_i <= w;
    s_wvalid_i <= w;
    s_bready_i <= w;
    s_arvalid_i <= !w;
    s_rready_i <= !w;
    forever begin
      #1;
      ta = pa & (w ? s_awready_o : s_arready_o);
      tw = pw & s_wready_o;
      tb = w ? s_bvalid_o : s_rvalid_o;
      r = w ? s_bresp_o : s_rresp_o;
      d = s_rdata_o;
      @(posedge core_clk_i);
      if (ta) s_awvalid_i <= 0;
      if (ta) s_arvalid_i <= 0;
      if (tw) s_wvalid_i <= 0;
      pa = pa & !ta;
      pw = pw & !tw;
      if (tb) break;
    end
    s_bready_i <= 0;
    s_rready_i <= 0;
  endtask : bus
  // Issue a command, wait for pending and busy to clear, check status.
  task automatic cmd(input logic [47:0] c, input logic [27:0] e);
    int i;
    bus(1, A_CDB_LO, c[31:0]);
    bus(1, A_CDB_HI, {16'h0, c[47:32]});
    for (i = 0; i < 300; i++) begin
      bus(0, A_STAT, 32'h0);
      if (d[30] === 1'b0 && d[28] === 1'b0) break;
    end
    chk("status", {4'h0, d[27:0]}, {4'h0, e});
  endtask : cmd
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial begin
    core_clk_i = 0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #300us;
    err_count++;
    stop_test;
  end
  initial begin
    {rst_b_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i} = 0;
    {s_rready_i, buf_pending_i, stale_buf_i, s_awaddr_i} = 0;
    {s_araddr_i, s_wdata_i, cfg} = 0;
    s_wstrb_i = 4'hf;
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1;
    bus(0, A_CTRL, 32'h0);
    chk("ctrl", d, {29'h0, CTRL_RST});
    bus(0, A_STAT, 32'h0);
    chk("stat", d, 32'h0);
    bus(0, 8'h14, 32'h0);
    chk("unmapped", {r, d[29:0]}, {RESP_DEC, 30'h0});
    bus(1, A_STAT, 32'h0);
    chk("ro write", {30'h0, r}, {30'h0, RESP_DEC});
    bus(1, A_CTRL, 32'h7);
    cmd(dg(3'h4, 0, 0, 0), {ASCQ_LOCK, ASC_LOCK, SK_ILLEGAL, ST_CHECK});
    bus(1, A_CTRL, 32'h1);
    cmd(dg(3'h4, 0, 0, 0), {ASCQ_LOCK, ASC_LOCK, SK_ILLEGAL, ST_CHECK});
    bus(1, A_CTRL, 32'h5);
    cmd(dg(3'h4, 1, 0, 0), ILL);
    cmd(dg(3'h4, 0, 1, 16'h0), ILL);
    cmd(dg(3'h0, 0, 1, DUMP_MAX), GD);
    bus(0, A_DUMP, 32'h0);
    chk("dump top", d, {23'h1, DUMP_MAX[7:0] ^ 8'h5a});
    bus(0, A_DUMP, 32'h0);
    chk("dump wrap", d, {23'h1, 8'h5a});
    cfg <= 4'h1;
    cmd(dg(3'h4, 0, 0, 0), GD);
    repeat (10) begin
      x = xs(x);
      cfg <= {1'b0, x[4], 1'b0, x[3]};
      cmd(dg(x[2:0], 0, 0, 0), dexp(x[2:0], x[4], x[3]));
    end
    cfg <= 4'h0;
    cmd({40'h0, OP_REWIND}, GD);
    buf_pending_i <= 1;
    cmd({40'h0, OP_WRITE}, ILL);
    cfg <= 4'h2;
    cmd({40'h0, OP_REWIND}, {16'h0, SK_MEDIUM, ST_CHECK});
    cfg <= 4'h8;
    @(posedge core_clk_i);
    cfg <= 4'h1;
    cmd({40'h0, OP_WRITE}, ILL);
    cmd({39'h0, 1'b1, OP_REWIND}, GD);
    chk("rewinding", {31'h0, d[29]}, 32'h1);
    buf_pending_i <= 0;
    cmd(dg(3'h4, 0, 0, 0), GD);
    stale_buf_i <= 1;
    cmd({40'h0, OP_REWIND}, GD);
    stop_test;
  end
endmodule : tape_rewind_and_diagnostic_cmds_test

// ---- trdc_cmd.sv ----
// Command sequencer for the rewind and diagnostic commands of a
// tape drive, with its AXI4-Lite register slave.
// Assumes the tape mechanics, buffer manager and test engine answer on
// the handshake ports below, all synchronous to core_clk_i.
//
// Summary of operation
// - Rewind opcode moves tape to start
// - Release bus during rewind if allowed
// - Flush buffered writes before rewinding
// - Flush failure gives Check, no rewind
// - Already at start, empty: no motion
// - Hold new commands until rewind ends
// - Discard data of failed write first
// - Early status bit picks status timing
// - Early status: flush, Good, then rewind
// - Diagnostic runs test, Good or Check
// - Locked or no autoload: 5/53/02
// - Page format flag must be zero
// - Dump with test bits: 5/24/00
// - Only tests 100 to 111 accepted
// - Length is dump start, max 97FFh
// - Dump address wraps past 97FFh
// - Dump address selects memory region
// - Dump ends quietly after all bytes
// - Test 100 needs proper setup
// - Test cancels sync, clears trace, locks
module trdc_cmd
  import trdc_pkg::*;
(
  input  wire logic        core_clk_i,   // System clock.
  input  wire logic        rst_b_i,      // Synchronous reset.
  input  wire logic [7:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [7:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  input  wire logic        at_start_i,   // Tape at start point.
  input  wire logic        buf_pending_i, // Buffer holds data.
  input  wire logic        stale_buf_i,  // Data of a failed write.
  input  wire logic        flush_done_i, // Flush and end mark done.
  input  wire logic        flush_err_i,  // Flush failed.
  input  wire logic        cart_present_i, // Cartridge inserted.
  input  wire logic        test_done_i,  // Self test finished.
  input  wire logic        test_pass_i,  // Self test found no error.
  input  wire logic [7:0]  dump_data_i,  // Byte at dump_addr_o.
  output logic             rewind_req_o, // Keep rewinding.
  output logic             flush_req_o,  // Write buffer and end mark.
  output logic             discard_o,    // Drop buffered data.
  output logic             test_req_o,   // Run selected test.
  output logic [2:0]       test_sel_o,   // Selected test code.
  output logic             sync_cancel_o, // Drop sync agreements.
  output logic             trace_clear_o, // Clear trace tables.
  output logic             unload_dis_o, // Unload button disabled.
  output logic             bus_release_o, // Bus released.
  output logic             status_valid_o, // Status phase pulse.
  output logic [7:0]       status_byte_o, // Status byte.
  output logic [15:0]      dump_addr_o,  // Current dump address.
  output logic [1:0]       dump_region_o // 0 chip, 1 RAM, 2 regs.
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  // Merges a write into a word under its byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // Builds the sense triple of an illegal field.
  function automatic trdc_sense_t bad_field();
    return '{ascq: ASCQ_FIELD, asc: ASC_FIELD, key: SK_ILLEGAL};
  endfunction : bad_field

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  trdc_state_t state;        // Sequencer state.
  logic [31:0] cdb_lo;       // Command bytes 0 to 3.
  logic [31:0] cdb_hi;       // Command bytes 4 and 5.
  logic [CTRL_W-1:0] ctrl;   // Control bits.
  logic        aw_hold;      // Write address taken.
  logic [7:0]  aw_addr;      // Held write address.
  logic        w_hold;       // Write data taken.
  logic [31:0] w_data;       // Held write data.
  logic [3:0]  w_strb;       // Held strobes.
  logic        cmd_pend;     // Command waits to run.
  logic        rewinding;    // Tape travelling to start.
  logic        immed;        // Early status of current command.
  logic        last_wr;      // Previous command wrote data.
  trdc_sense_t sense;        // Current sense data.
  logic [15:0] dump_left;    // Dump bytes still on offer.
  logic        wr_en;        // Register write this cycle.
  logic        rd_en;        // Register read this cycle.
  logic        dump_rd;      // Read of an available dump byte.
  logic [7:0]  op;           // Opcode byte.
  logic [7:0]  byte1;        // Flags byte.
  logic [15:0] plen;         // Parameter length field.
  logic        md;           // Dump request bit.
  trdc_stat_t  stat;         // Status register view.

  assign op    = cdb_lo[7:0];
  assign byte1 = cdb_lo[15:8];
  assign plen  = {cdb_lo[31:24], cdb_hi[7:0]};
  assign md    = cdb_hi[8 + MD_BIT];

  // ------------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------------
  // Address and data are taken in either order; the answer follows
  // one cycle after both are held.
  assign s_awready_o = !aw_hold && !s_bvalid_o;
  assign s_wready_o  = !w_hold && !s_bvalid_o;
  assign wr_en       = aw_hold && w_hold;

  // Holds address and data until the write is performed.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_hold <= 1'b1;
        aw_addr <= s_awaddr_i;
      end else if (wr_en) begin
        aw_hold <= 1'b0;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_hold <= 1'b1;
        w_data <= s_wdata_i;
        w_strb <= s_wstrb_i;
      end else if (wr_en) begin
        w_hold <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only words answer DECERR.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_bvalid_o <= 1'b0;
      s_bresp_o  <= RESP_OK;
    end else if (wr_en) begin
      s_bvalid_o <= 1'b1;
      s_bresp_o  <= (aw_addr == A_CDB_LO || aw_addr == A_CDB_HI ||
                     aw_addr == A_CTRL) ? RESP_OK : RESP_DEC;
    end else if (s_bready_i) begin
      s_bvalid_o <= 1'b0;
    end
  end

  // Command words are frozen while a command waits, so a held command
  // cannot be corrupted; the host polls the pending bit first.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cdb_lo <= CDB_RST;
      cdb_hi <= CDB_RST;
      ctrl   <= CTRL_RST;
    end else if (wr_en) begin
      if (aw_addr == A_CDB_LO && !cmd_pend) begin
        cdb_lo <= merge(cdb_lo, w_data, w_strb);
      end
      if (aw_addr == A_CDB_HI && !cmd_pend) begin
        cdb_hi <= merge(cdb_hi, w_data, w_strb) & 32'h0000_ffff;
      end
      if (aw_addr == A_CTRL && w_strb[0]) begin
        ctrl <= w_data[CTRL_W-1:0];
      end
    end
  end

  // A write to the upper command word issues the command.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cmd_pend <= 1'b0;
    end else if (wr_en && aw_addr == A_CDB_HI && !cmd_pend) begin
      cmd_pend <= 1'b1;
    end else if (state == S_IDLE && !rewinding) begin
      cmd_pend <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------------
  assign s_arready_o = !s_rvalid_o;
  assign rd_en       = s_arvalid_i && s_arready_o;
  assign dump_rd     = rd_en && s_araddr_i == A_DUMP && dump_left != 0;
  assign stat = '{bus_rel: bus_release_o, pend: cmd_pend,
                  rew: rewinding, busy: state != S_IDLE,
                  sense: sense, status: status_byte_o};

  // Registered read data; a dump read returns the byte and a valid flag.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_rvalid_o <= 1'b0;
      s_rdata_o  <= 32'h0;
      s_rresp_o  <= RESP_OK;
    end else if (rd_en) begin
      s_rvalid_o <= 1'b1;
      s_rresp_o  <= RESP_OK;
      unique case (s_araddr_i)
        A_CDB_LO: s_rdata_o <= cdb_lo;
        A_CDB_HI: s_rdata_o <= cdb_hi;
        A_CTRL:   s_rdata_o <= {29'h0, ctrl};
        A_STAT:   s_rdata_o <= stat;
        A_DUMP:   s_rdata_o <= {23'h0, dump_rd, dump_data_i};
        default: begin
          s_rdata_o <= 32'h0;
          s_rresp_o <= RESP_DEC;
        end
      endcase
    end else if (s_rready_i) begin
      s_rvalid_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Memory dump pointer
  // ------------------------------------------------------------------
  // Each dump read of an available byte steps the address; once every available byte has
  // gone, reads return no valid flag and no error is raised.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      dump_addr_o <= 16'h0;
      dump_left   <= 16'h0;
    end else if (state == S_DEC && op == OP_DIAG && md) begin
      dump_addr_o <= plen;
      dump_left   <= DUMP_AVAIL;
    end else if (dump_rd) begin
      dump_addr_o <= (dump_addr_o == DUMP_MAX) ? 16'h0 :
                     dump_addr_o + 16'h1;
      dump_left   <= dump_left - 16'h1;
    end
  end

  // Memory region of the current dump address.
  always_comb begin
    if (dump_addr_o <= CHIP_TOP) begin
      dump_region_o = 2'd0;
    end else if (dump_addr_o <= RAM_TOP) begin
      dump_region_o = 2'd1;
    end else begin
      dump_region_o = 2'd2;
    end
  end

  // ------------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------------
  assign rewind_req_o  = rewinding;
  assign flush_req_o   = state == S_FLUSH;
  assign test_req_o    = state == S_DIAG;
  assign unload_dis_o  = state == S_DIAG;
  // The bus is released during slow phases if allowed; tests always disconnect.
  assign bus_release_o = (ctrl[CTRL_DISC] &&
                          (state == S_FLUSH || state == S_REW)) ||
                         state == S_DIAG;

  // Main state flow, pulses and status for both commands.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state          <= S_IDLE;
      rewinding      <= 1'b0;
      immed          <= 1'b0;
      last_wr        <= 1'b0;
      sense          <= '{ascq: 8'h0, asc: 8'h0, key: SK_NONE};
      status_valid_o <= 1'b0;
      status_byte_o  <= ST_GOOD;
      discard_o      <= 1'b0;
      sync_cancel_o  <= 1'b0;
      trace_clear_o  <= 1'b0;
      test_sel_o     <= 3'h0;
    end else begin
      status_valid_o <= 1'b0;
      discard_o      <= 1'b0;
      sync_cancel_o  <= 1'b0;
      trace_clear_o  <= 1'b0;
      if (rewinding && at_start_i) begin
        rewinding <= 1'b0;
      end
      unique case (state)
        S_IDLE: begin
          // New commands wait here until the tape reaches its start.
          if (cmd_pend && !rewinding) begin
            state <= S_DEC;
            immed <= byte1[IMMED_BIT];
          end
        end
        S_DEC: begin
          last_wr <= op == OP_WRITE || op == OP_WFM;
          sense   <= '{ascq: 8'h0, asc: 8'h0, key: SK_NONE};
          state   <= S_DONE;
          status_byte_o <= ST_CHECK;
          if (op == OP_REWIND) begin
            status_byte_o <= ST_GOOD;
            if (stale_buf_i) begin
              discard_o <= 1'b1;
              state     <= S_REW;
            end else if (last_wr && buf_pending_i) begin
              state <= S_FLUSH;
            end else if (at_start_i && !buf_pending_i) begin
              state <= S_DONE;
            end else begin
              state <= S_REW;
            end
          end else if (op == OP_DIAG) begin
            if (ctrl[CTRL_LOCK] || !ctrl[CTRL_AUTO]) begin
              sense <= '{ascq: ASCQ_LOCK, asc: ASC_LOCK,
                         key: SK_ILLEGAL};
            end else if (byte1[PF_BIT]) begin
              sense <= bad_field();
            end else if (md) begin
              if (byte1[2:0] != 3'b000 || plen > DUMP_MAX) begin
                sense <= bad_field();
              end else begin
                status_byte_o <= ST_GOOD;
              end
            end else if (!byte1[2] || plen != 16'h0) begin
              sense <= bad_field();
            end else if (cart_present_i != byte1[1]) begin
              sense <= bad_field();
            end else begin
              state         <= S_DIAG;
              test_sel_o    <= byte1[2:0];
              sync_cancel_o <= 1'b1;
              trace_clear_o <= 1'b1;
            end
          end else begin
            sense <= bad_field();
          end
        end
        S_FLUSH: begin
          if (flush_err_i) begin
            state         <= S_DONE;
            status_byte_o <= ST_CHECK;
            sense <= '{ascq: 8'h0, asc: 8'h0, key: SK_MEDIUM};
          end else if (flush_done_i) begin
            state <= S_REW;
          end
        end
        S_REW: begin
          // Early status answers now; otherwise wait for the start.
          rewinding <= 1'b1;
          last_wr   <= 1'b0;
          if (immed) begin
            state <= S_DONE;
          end else if (rewinding && at_start_i) begin
            state <= S_DONE;
          end
        end
        S_DIAG: begin
          if (test_done_i) begin
            state         <= S_DONE;
            status_byte_o <= test_pass_i ? ST_GOOD : ST_CHECK;
            if (!test_pass_i) begin
              sense <= '{ascq: 8'h0, asc: 8'h0, key: SK_HW};
            end
          end
        end
        S_DONE: begin
          status_valid_o <= 1'b1;
          state          <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_rew_motion;
    state == S_REW |=> rewind_req_o;
  endproperty
  a_rew_motion: assert property (p_rew_motion)
    else $error("rewind not driven");

  property p_flush_fail;
    state == S_FLUSH && flush_err_i |=> ##1 status_valid_o &&
      status_byte_o == ST_CHECK && !rewind_req_o;
  endproperty
  a_flush_fail: assert property (p_flush_fail)
    else $error("flush failure not reported");

  property p_no_motion;
    state == S_DEC && op == OP_REWIND && at_start_i &&
      !buf_pending_i && !stale_buf_i |=> state == S_DONE ##1
      !rewind_req_o && status_byte_o == ST_GOOD;
  endproperty
  a_no_motion: assert property (p_no_motion)
    else $error("tape moved while at start");

  property p_hold_cmd;
    rewinding |-> state != S_DEC;
  endproperty
  a_hold_cmd: assert property (p_hold_cmd)
    else $error("command ran during rewind");

  property p_early;
    state == S_REW && immed |=> ##1 status_valid_o && rewinding;
  endproperty
  a_early: assert property (p_early)
    else $error("early status late");

  property p_locked;
    state == S_DEC && op == OP_DIAG && ctrl[CTRL_LOCK] |=>
      sense.asc == ASC_LOCK && sense.ascq == ASCQ_LOCK ##1
      status_valid_o && status_byte_o == ST_CHECK;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked diagnostic not refused");

  property p_wrap;
    dump_rd && dump_addr_o == DUMP_MAX |=> dump_addr_o == 16'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("dump address did not wrap");

  property p_test_side;
    state == S_DEC && $past(state) == S_IDLE ##1 state == S_DIAG
      |-> sync_cancel_o && trace_clear_o && unload_dis_o;
  endproperty
  a_test_side: assert property (p_test_side)
    else $error("test entry effects missing");

  property p_release;
    state == S_FLUSH && ctrl[CTRL_DISC] |-> bus_release_o;
  endproperty
  a_release: assert property (p_release)
    else $error("bus kept during flush");

endmodule : trdc_cmd

// ---- trdc_mech.sv ----
// Behavioural model of the tape mechanics, buffer and test engine.
// Assumes the command block's request levels, all on core_clk_i.
module trdc_mech
  import trdc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  cfg_i,
  input  wire logic        flush_req_i,
  input  wire logic        test_req_i,
  input  wire logic        rewind_req_i,
  input  wire logic [15:0] dump_addr_i,
  output logic             at_start_o,
  output logic             flush_done_o,
  output logic             flush_err_o,
  output logic             test_done_o,
  output logic [7:0]       dump_data_o
);
  logic [3:0] cnt; // Cycles spent on the request now open.
  // Answers come a few cycles late, so no zero-latency path hides.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || !(flush_req_i | test_req_i | rewind_req_i)) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
    flush_done_o <= flush_req_i && cnt == 4'h4 && !cfg_i[1];
    flush_err_o  <= flush_req_i && cnt == 4'h4 && cfg_i[1];
    test_done_o  <= test_req_i && cnt == 4'h4;
    if (!rst_b_i) begin
      at_start_o <= 1'b1;
    end else if (cfg_i[3]) begin
      at_start_o <= 1'b0;
    end else if (rewind_req_i && cnt == 4'hf) begin
      at_start_o <= 1'b1;
    end
  end
  assign dump_data_o = dump_addr_i[7:0] ^ 8'h5a; // Known pattern.
endmodule : trdc_mech

// ---- trdc_pkg.sv ----
// Constants, types and register layout of the tape rewind and
// diagnostic command block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite master.
package trdc_pkg;

  // ------------------------------------------------------------------
  // Command opcodes and status bytes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_REWIND = 8'h01; // Rewind command.
  localparam logic [7:0] OP_WRITE  = 8'h0a; // Write command.
  localparam logic [7:0] OP_WFM    = 8'h10; // Write filemarks command.
  localparam logic [7:0] OP_DIAG   = 8'h1d; // Diagnostic command.
  localparam logic [7:0] ST_GOOD   = 8'h00; // Good status byte.
  localparam logic [7:0] ST_CHECK  = 8'h02; // Check Condition byte.

  // ------------------------------------------------------------------
  // Sense codes
  // ------------------------------------------------------------------
  localparam logic [3:0] SK_NONE   = 4'h0; // No sense.
  localparam logic [3:0] SK_MEDIUM = 4'h3; // Medium error on flush.
  localparam logic [3:0] SK_HW     = 4'h4; // Failed self test.
  localparam logic [3:0] SK_ILLEGAL = 4'h5; // Illegal request.
  localparam logic [7:0] ASC_LOCK  = 8'h53; // Removal locked code.
  localparam logic [7:0] ASCQ_LOCK = 8'h02; // Removal locked qual.
  localparam logic [7:0] ASC_FIELD = 8'h24; // Invalid field code.
  localparam logic [7:0] ASCQ_FIELD = 8'h00; // Invalid field qual.

  // ------------------------------------------------------------------
  // Command block field positions
  // ------------------------------------------------------------------
  localparam int IMMED_BIT = 0; // Early status, byte 1.
  localparam int PF_BIT    = 4; // Page format flag, byte 1.
  localparam int MD_BIT    = 7; // Dump request bit, byte 5.

  // ------------------------------------------------------------------
  // Memory dump address space
  // ------------------------------------------------------------------
  localparam logic [15:0] DUMP_MAX   = 16'h97ff; // Last dump address.
  localparam logic [15:0] DUMP_AVAIL = 16'h9064; // Bytes on offer.
  localparam logic [15:0] CHIP_TOP   = 16'h00ff; // End of chip memory.
  localparam logic [15:0] RAM_TOP    = 16'h7fff; // End of external RAM.

  // ------------------------------------------------------------------
  // Register map (byte addresses) and control bits
  // ------------------------------------------------------------------
  localparam logic [7:0] A_CDB_LO = 8'h00; // Command bytes 0 to 3.
  localparam logic [7:0] A_CDB_HI = 8'h04; // Bytes 4, 5; issues.
  localparam logic [7:0] A_CTRL   = 8'h08; // Control bits.
  localparam logic [7:0] A_STAT   = 8'h0c; // Status and sense.
  localparam logic [7:0] A_DUMP   = 8'h10; // Dump data port.
  localparam int CTRL_DISC = 0; // Initiator allows disconnection.
  localparam int CTRL_LOCK = 1; // Medium removal is locked.
  localparam int CTRL_AUTO = 2; // Autoloading is enabled.
  localparam int CTRL_W    = 3; // Implemented control width.
  localparam logic [2:0]  CTRL_RST = 3'h4;  // Autoload on at reset.
  localparam logic [31:0] CDB_RST  = 32'h0; // Command words at reset.
  localparam logic [1:0]  RESP_OK  = 2'b00; // AXI OKAY.
  localparam logic [1:0]  RESP_DEC = 2'b11; // AXI DECERR.

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  // Sense triple reported after Check Condition.
  typedef struct packed {
    logic [7:0] ascq;
    logic [7:0] asc;
    logic [3:0] key;
  } trdc_sense_t;

  // Layout of the status register, most significant field first.
  typedef struct packed {
    logic        bus_rel;
    logic        pend;
    logic        rew;
    logic        busy;
    trdc_sense_t sense;
    logic [7:0]  status;
  } trdc_stat_t;

  // Command sequencer states.
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_DEC   = 3'b001,
    S_FLUSH = 3'b010,
    S_REW   = 3'b011,
    S_DIAG  = 3'b100,
    S_DONE  = 3'b101
  } trdc_state_t;

endpackage : trdc_pkg
